// [verilog/dtf_regs.sv]
// task-file error, features, count, position and status registers
`timescale 1ns/1ps
`default_nettype none
module dtf_regs #(
   parameter int DATA_W = 16,
   parameter bit PACKET_DEV = 1'b0,
   parameter logic [7:0] RESET_CMD_CODE = 8'h08,
   parameter logic [7:0] DIAG_CMD_CODE = 8'h90,
   parameter logic [7:0] DIAG_RESET_CODE = 8'h01
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic block_select_low,
   input wire logic block_select_high,
   input wire logic reg_addr_bit0,
   input wire logic reg_addr_bit1,
   input wire logic reg_addr_bit2,
   input wire logic host_rd,
   input wire logic host_wr,
   input wire logic [DATA_W-1:0] host_data_in,
   output logic [DATA_W-1:0] host_data_out,
   output logic host_data_oe_n,
   input wire logic dma_acknowledge_n,
   input wire logic soft_reset_bit,
   input wire logic sleep_mode,
   input wire dtf_pkg::dtf_core_ev_s core_ev,
   input wire logic [7:0] core_error_bits,
   input wire logic [7:0] core_diag_code,
   input wire logic [7:0] core_count_val,
   input wire logic [7:0] core_pos_val,
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   output dtf_pkg::dtf_cmd_params_s cmd_params,
   output logic intr_clear,
   output logic [7:0] status_out
);
   if (DATA_W < 8)
      $error("dtf_regs: data bus narrower than one byte");

   logic busy_flag;
   logic transfer_request_flag;
   logic accept_ready_flag;
   logic error_flag;
   logic service_request_flag;
   logic dep_flag;
   logic reset_phase;
   logic soft_reset_bit_d;
   logic [7:0] command_error_result;
   logic [7:0] command_feature_param;
   logic [7:0] transfer_count_param;
   logic [7:0] block_position_param;
   logic [7:0] device_state_flags;
   logic [7:0] wbyte;
   logic [2:0] addr;
   logic sel;
   logic soft_reset_bit_rise;
   logic wr_cmd_any;
   logic reset_cmd;
   logic cmd_ok;
   logic wr_ok;
   logic rd_ok;
   logic reg_busy_ok;
   logic [7:0] next_rdata;

   // register-port access only with dma acknowledge negated
   assign addr = {reg_addr_bit2, reg_addr_bit1, reg_addr_bit0};
   assign sel = block_select_low & ~block_select_high & dma_acknowledge_n;
   assign wbyte = host_data_in[7:0];
   assign soft_reset_bit_rise = soft_reset_bit & ~soft_reset_bit_d;
   assign wr_cmd_any = sel & host_wr & (addr == dtf_pkg::ADDR_STAT_CMD);
   // only the device-reset code gets through while busy
   assign reset_cmd = wr_cmd_any & (wbyte == RESET_CMD_CODE);
   assign cmd_ok = wr_cmd_any & (~busy_flag | reset_cmd);
   assign wr_ok = sel & host_wr & ~busy_flag;
   assign rd_ok = sel & host_rd;
   assign reg_busy_ok = busy_flag | transfer_request_flag;

   always_ff @(posedge clk)
   begin
      if (reset)
         soft_reset_bit_d <= 1'b0;
      else
         soft_reset_bit_d <= soft_reset_bit;
   end

   // reset phase lasts until the core can take commands without ready
   always_ff @(posedge clk)
   begin
      if (reset)
         reset_phase <= 1'b1;
      else if (soft_reset_bit_rise | reset_cmd)
         reset_phase <= 1'b1;
      else if (core_ev.reset_ready)
         reset_phase <= 1'b0;
   end

   // busy and request move together so one is always set mid-command
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         busy_flag <= 1'b1;
         transfer_request_flag <= 1'b0;
      end
      else if (soft_reset_bit_rise | reset_cmd)
      begin
         busy_flag <= 1'b1;
         transfer_request_flag <= 1'b0;
      end
      else if (cmd_ok)
         busy_flag <= 1'b1;
      else if (busy_flag & core_ev.data_ready)
      begin
         transfer_request_flag <= 1'b1;
         busy_flag <= 1'b0;
      end
      else if (transfer_request_flag & (core_ev.block_done | core_ev.last_word))
      begin
         transfer_request_flag <= 1'b0;
         busy_flag <= 1'b1;
      end
      else if (reg_busy_ok & (core_ev.complete | core_ev.bus_release))
      begin
         busy_flag <= 1'b0;
         transfer_request_flag <= 1'b0;
      end
      else if (reset_phase & core_ev.reset_ready)
         busy_flag <= 1'b0;
   end

   // ready: non-packet on core readiness, packet on completion of a non-diagnostic command
   always_ff @(posedge clk)
   begin
      if (reset)
         accept_ready_flag <= 1'b0;
      else if (soft_reset_bit_rise | reset_cmd)
      begin
         if (PACKET_DEV)
            accept_ready_flag <= 1'b0;
      end
      else if (cmd_ok & PACKET_DEV & (wbyte == DIAG_CMD_CODE))
         accept_ready_flag <= 1'b0;
      else if (!PACKET_DEV & core_ev.ready_all)
         accept_ready_flag <= 1'b1;
      // diagnostic completion leaves ready clear for packet devices
      else if (PACKET_DEV & core_ev.complete & reg_busy_ok & ~reset_phase
         & (cmd_code != DIAG_CMD_CODE))
         accept_ready_flag <= 1'b1;
   end

   dtf_flag u_error_flag (
      .clk(clk),
      .reset(reset),
      .set(reg_busy_ok & core_ev.complete & core_ev.error),
      .clear(cmd_ok | soft_reset_bit_rise),
      .q(error_flag)
   );

   dtf_flag u_service_flag (
      .clk(clk),
      .reset(reset),
      .set(~busy_flag & core_ev.service),
      .clear(cmd_ok | soft_reset_bit_rise),
      .q(service_request_flag)
   );

   always_ff @(posedge clk)
   begin
      if (reset)
         dep_flag <= 1'b0;
      else if (reg_busy_ok & core_ev.complete)
         dep_flag <= core_ev.error & core_ev.abort;
   end

   // apart from soft reset, error register changes only while the device owns the block
   always_ff @(posedge clk)
   begin
      if (reset)
         command_error_result <= DIAG_RESET_CODE;
      else if (soft_reset_bit_rise)
         command_error_result <= DIAG_RESET_CODE;
      else if (reg_busy_ok & core_ev.diag_done)
         command_error_result <= core_diag_code;
      else if (reg_busy_ok & core_ev.complete & core_ev.error)
      begin
         if (core_ev.abort)
            command_error_result <= core_error_bits
               | dtf_pkg::ABORT_MASK;
         else
            command_error_result <= core_error_bits;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         command_feature_param <= dtf_pkg::BYTE_ZERO;
      else if (wr_ok & (addr == dtf_pkg::ADDR_ERR_FEAT))
         command_feature_param <= wbyte;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         transfer_count_param <= dtf_pkg::BYTE_ZERO;
      else if (wr_ok & (addr == dtf_pkg::ADDR_COUNT))
         transfer_count_param <= wbyte;
      else if (reg_busy_ok & core_ev.update_regs)
         transfer_count_param <= core_count_val;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         block_position_param <= dtf_pkg::BYTE_ZERO;
      else if (wr_ok & (addr == dtf_pkg::ADDR_POSITION))
         block_position_param <= wbyte;
      else if (reg_busy_ok & core_ev.update_regs)
         block_position_param <= core_pos_val;
   end

   always_comb
   begin
      device_state_flags = dtf_pkg::BYTE_ZERO;
      device_state_flags[dtf_pkg::BIT_BUSY] = busy_flag;
      device_state_flags[dtf_pkg::BIT_READY] = accept_ready_flag;
      device_state_flags[dtf_pkg::BIT_DEP] = dep_flag;
      device_state_flags[dtf_pkg::BIT_SERVICE] = service_request_flag;
      device_state_flags[dtf_pkg::BIT_REQUEST] = transfer_request_flag;
      device_state_flags[dtf_pkg::BIT_ERROR] = error_flag;
   end

   // command launch captures the parameter block
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         cmd_valid <= 1'b0;
         cmd_code <= dtf_pkg::BYTE_ZERO;
         cmd_params <= '0;
      end
      else
      begin
         cmd_valid <= cmd_ok;
         if (cmd_ok)
         begin
            cmd_code <= wbyte;
            cmd_params.features <= command_feature_param;
            cmd_params.count <= transfer_count_param;
            cmd_params.position <= block_position_param;
         end
      end
   end

   always_comb
   begin
      next_rdata = dtf_pkg::BYTE_ZERO;
      unique case (addr)
         dtf_pkg::ADDR_ERR_FEAT: next_rdata = command_error_result;
         dtf_pkg::ADDR_COUNT: next_rdata = transfer_count_param;
         dtf_pkg::ADDR_POSITION: next_rdata = block_position_param;
         dtf_pkg::ADDR_STAT_CMD: next_rdata = device_state_flags;
         default: next_rdata = dtf_pkg::BYTE_ZERO;
      endcase
      if (sleep_mode)
         next_rdata = dtf_pkg::SLEEP_READ;
   end

   // read data stands one cycle after the strobe, upper byte zero
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         host_data_out <= '0;
         host_data_oe_n <= 1'b1;
      end
      else
      begin
         host_data_oe_n <= ~rd_ok;
         if (rd_ok)
            host_data_out <= {{(DATA_W-8){1'b0}}, next_rdata};
      end
   end

   // an accepted command write also drops the pending interrupt
   always_ff @(posedge clk)
   begin
      if (reset)
         intr_clear <= 1'b0;
      else
         intr_clear <= (rd_ok & (addr == dtf_pkg::ADDR_STAT_CMD)) | cmd_ok;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         status_out <= dtf_pkg::BYTE_ZERO;
      else
         status_out <= device_state_flags;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_cmd_sets_busy: assert property (cmd_ok |=> busy_flag)
      else $error("command write did not set busy");
   a_busy_blocks_wr: assert property (busy_flag && sel && host_wr
      && addr == dtf_pkg::ADDR_COUNT && !core_ev.update_regs
      |=> $stable(transfer_count_param))
      else $error("count changed by host write while busy");
   a_params_captured: assert property (cmd_ok |=> cmd_valid
      && cmd_params.features == $past(command_feature_param)
      && cmd_params.count == $past(transfer_count_param))
      else $error("parameters not captured at command write");
   a_err_cleared: assert property (cmd_ok && !reg_busy_ok
      |=> !error_flag)
      else $error("error bit not cleared by new command");
   a_no_idle_request: assert property (!busy_flag && !transfer_request_flag
      && !cmd_ok |=> !transfer_request_flag)
      else $error("request raised while not busy");
   a_busy_or_request: assert property ((busy_flag || transfer_request_flag)
      && !core_ev.complete && !core_ev.bus_release && !core_ev.reset_ready
      |=> busy_flag || transfer_request_flag)
      else $error("busy and request dropped before completion");
   a_status_layout: assert property (rd_ok && !sleep_mode
      && addr == dtf_pkg::ADDR_STAT_CMD
      |=> host_data_out[7] == $past(busy_flag)
      && host_data_out[3] == $past(transfer_request_flag)
      && host_data_out[0] == $past(error_flag) && !host_data_oe_n)
      else $error("status byte layout wrong");
   a_abort_bit: assert property (reg_busy_ok && core_ev.complete
      && core_ev.error && core_ev.abort && !core_ev.diag_done && !soft_reset_bit_rise
      |=> command_error_result[dtf_pkg::BIT_ABORT] && error_flag)
      else $error("abort bit not set");
   a_last_word: assert property (transfer_request_flag && core_ev.last_word
      && !soft_reset_bit_rise && !reset_cmd && !cmd_ok |=> !transfer_request_flag
      ##0 busy_flag)
      else $error("request not cleared on last word");
   a_error_readback: assert property (rd_ok && !sleep_mode
      && addr == dtf_pkg::ADDR_ERR_FEAT
      |=> host_data_out[7:0] == $past(command_error_result))
      else $error("error address did not return error register");
endmodule
`default_nettype wire

// [common/dtf_pkg.sv]
// constants and types for the task-file register block
package dtf_pkg;
   localparam logic [2:0] ADDR_ERR_FEAT = 3'h1;
   localparam logic [2:0] ADDR_COUNT = 3'h2;
   localparam logic [2:0] ADDR_POSITION = 3'h3;
   localparam logic [2:0] ADDR_STAT_CMD = 3'h7;
   localparam int BIT_BUSY = 7;
   localparam int BIT_READY = 6;
   localparam int BIT_DEP = 5;
   localparam int BIT_SERVICE = 4;
   localparam int BIT_REQUEST = 3;
   localparam int BIT_ERROR = 0;
   localparam int BIT_ABORT = 2;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] SLEEP_READ = 8'hFF;
   localparam logic [7:0] ABORT_MASK = 8'h04;

   typedef struct packed {
      logic [7:0] features;
      logic [7:0] count;
      logic [7:0] position;
   } dtf_cmd_params_s;

   typedef struct packed {
      logic reset_ready;
      logic ready_all;
      logic data_ready;
      logic block_done;
      logic last_word;
      logic complete;
      logic error;
      logic abort;
      logic bus_release;
      logic service;
      logic diag_done;
      logic update_regs;
   } dtf_core_ev_s;
endpackage

// [verilog/dtf_flag.sv]
// sticky flag with set winning over clear
`timescale 1ns/1ps
`default_nettype none
module dtf_flag #(
   parameter logic RESET_VAL = 1'b0
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic set,
   input wire logic clear,
   output logic q
);
   always_ff @(posedge clk)
   begin
      if (reset)
         q <= RESET_VAL;
      else if (set)
         q <= 1'b1;
      else if (clear)
         q <= 1'b0;
   end
endmodule
`default_nettype wire

// [testbench/dtf_host_model.sv]
// host adapter model driving the task-file register bus
`timescale 1ns/1ps
`default_nettype none
module dtf_host_model (
   input wire logic clk,
   output logic sel_low,
   output logic sel_high,
   output logic [2:0] addr,
   output logic rd,
   output logic wr,
   output logic [15:0] wdata,
   output logic dma_n,
   input wire logic [15:0] rdata,
   input wire logic rdata_oe_n
);
   initial
   begin
      sel_low = 1'b0;
      sel_high = 1'b0;
      addr = 3'h5;
      rd = 1'b0;
      wr = 1'b0;
      wdata = 16'hA5A5;
      dma_n = 1'b1;
   end
   // one strobe per access; callers write only while idle with dma negated
   // except where a refusal or the device-reset code is the point of the test
   task automatic acc(input bit w, input logic [2:0] a, input logic [7:0] d,
      input bit dm, output logic [16:0] q);
      @(negedge clk);
      sel_low = 1'b1;
      addr = a;
      rd = !w;
      wr = w;
      wdata = {~d, d};
      dma_n = !dm;
      @(negedge clk);
      q = {rdata_oe_n, rdata};
      sel_low = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      dma_n = 1'b1;
      // released lines flip so a stale value is never mistaken for a hold
      addr = ~a;
      wdata = ~wdata;
   endtask
endmodule
`default_nettype wire

// [testbench/dtf_regs_tb_top.sv]
// self-checking bench for the task-file register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) \
      begin \
         err_count++; \
         $display("ERROR %0t: got %h expected %h", $time, got, exp); \
      end \
   end
module dtf_regs_tb_top;
   localparam logic [7:0] RST_CODE = 8'h08;
   localparam logic [7:0] DIAG_CODE = 8'h90;
   localparam logic [7:0] DIAG_RST = 8'h01;
   logic clk, reset, sel_low, sel_high, rd, wr, dma_n, soft_rst, sleep;
   logic rdata_oe_n, cmd_valid, intr_clear;
   logic [2:0] addr;
   logic [15:0] wdata, rdata;
   logic [7:0] ebits, diag, cnt_v, pos_v, cmd_code, status_out;
   logic [7:0] f, c, p, code, eerr;
   logic [16:0] q;
   dtf_pkg::dtf_core_ev_s ev, evn, ev_idle;
   dtf_pkg::dtf_cmd_params_s params;
   int err_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   int seed, i;
   bit er, ab, dp;

   dtf_regs #(.DATA_W(16), .PACKET_DEV(1'b0), .RESET_CMD_CODE(RST_CODE),
      .DIAG_CMD_CODE(DIAG_CODE), .DIAG_RESET_CODE(DIAG_RST)) DUT (
      .clk(clk), .reset(reset), .block_select_low(sel_low),
      .block_select_high(sel_high), .reg_addr_bit0(addr[0]),
      .reg_addr_bit1(addr[1]), .reg_addr_bit2(addr[2]), .host_rd(rd),
      .host_wr(wr), .host_data_in(wdata), .host_data_out(rdata),
      .host_data_oe_n(rdata_oe_n), .dma_acknowledge_n(dma_n),
      .soft_reset_bit(soft_rst), .sleep_mode(sleep), .core_ev(ev),
      .core_error_bits(ebits), .core_diag_code(diag),
      .core_count_val(cnt_v), .core_pos_val(pos_v), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_params(params), .intr_clear(intr_clear),
      .status_out(status_out));

   dtf_host_model host (.clk(clk), .sel_low(sel_low), .sel_high(sel_high),
      .addr(addr), .rd(rd), .wr(wr), .wdata(wdata), .dma_n(dma_n),
      .rdata(rdata), .rdata_oe_n(rdata_oe_n));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // expected status: ready is the inverse of busy, bits 5, 4, 2 and 1 are zero
   function automatic logic [7:0] st(input bit b, input bit r, input bit e);
      return {b, !b, 2'b00, r, 2'b00, e};
   endfunction

   task automatic report_and_stop;
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic rd_chk(input logic [2:0] a, input logic [7:0] m,
      input logic [7:0] e);
      host.acc(1'b0, a, 8'h00, 1'b0, q);
      `CHK(q[16:8], 9'h000);
      `CHK(q[7:0] & m, e);
   endtask

   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      host.acc(1'b1, a, d, 1'b0, q);
   endtask

   // each event line is driven once per step so no glitch reaches the core
   task automatic pulse;
      @(negedge clk);
      ev = evn | ev_idle;
      @(negedge clk);
      ev = ev_idle;
      evn = '0;
   endtask

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         err_count++;
         report_and_stop();
      end
   end

   initial
   begin
      seed = 32'h71a1;
      reset = 1'b1;
      soft_rst = 1'b0;
      sleep = 1'b0;
      ev_idle = '0;
      ev_idle.ready_all = 1'b1;
      ev = ev_idle;
      evn = '0;
      {ebits, diag, cnt_v, pos_v} = '0;
      eerr = DIAG_RST;
      repeat (6) @(negedge clk);
      reset = 1'b0;
      rd_chk(dtf_pkg::ADDR_STAT_CMD, 8'h80, 8'h80);
      wr_reg(dtf_pkg::ADDR_COUNT, 8'h3C);
      evn.reset_ready = 1'b1;
      pulse();
      rd_chk(dtf_pkg::ADDR_ERR_FEAT, 8'hFF, DIAG_RST);
      `CHK(intr_clear, 1'b0);
      rd_chk(dtf_pkg::ADDR_COUNT, 8'hFF, 8'h00);
      rd_chk(dtf_pkg::ADDR_STAT_CMD, 8'hC9, st(0, 0, 0));
      `CHK(intr_clear, 1'b1);
      for (i = 0; i < 24; i++)
      begin
         f = 8'($random(seed));
         c = 8'($random(seed));
         p = 8'($random(seed));
         code = 8'($random(seed));
         if (code == RST_CODE || code == DIAG_CODE)
            code = code ^ 8'h40;
         er = 1'($random(seed));
         ab = er & 1'($random(seed));
         dp = 1'($random(seed));
         wr_reg(dtf_pkg::ADDR_ERR_FEAT, f);
         wr_reg(dtf_pkg::ADDR_COUNT, c);
         wr_reg(dtf_pkg::ADDR_POSITION, p);
         rd_chk(dtf_pkg::ADDR_COUNT, 8'hFF, c);
         rd_chk(dtf_pkg::ADDR_POSITION, 8'hFF, p);
         rd_chk(dtf_pkg::ADDR_ERR_FEAT, 8'hFF, eerr);
         wr_reg(dtf_pkg::ADDR_STAT_CMD, code);
         `CHK(cmd_valid, 1'b1);
         `CHK(cmd_code, code);
         `CHK(params, {f, c, p});
         rd_chk(dtf_pkg::ADDR_STAT_CMD, 8'h80, 8'h80);
         cnt_v = 8'($random(seed));
         pos_v = 8'($random(seed));
         evn.update_regs = 1'b1;
         pulse();
         // a write while busy must not disturb the core's result
         wr_reg(dtf_pkg::ADDR_COUNT, ~cnt_v);
         if (dp)
         begin
            evn.data_ready = 1'b1;
            pulse();
            rd_chk(dtf_pkg::ADDR_STAT_CMD, 8'hC9, st(0, 1, 0));
            evn.block_done = 1'b1;
            pulse();
            rd_chk(dtf_pkg::ADDR_STAT_CMD, 8'h88, 8'h80);
            evn.data_ready = 1'b1;
            pulse();
            evn.last_word = 1'b1;
            pulse();
            rd_chk(dtf_pkg::ADDR_STAT_CMD, 8'h88, 8'h80);
         end
         ebits = 8'($random(seed));
         evn.complete = 1'b1;
         evn.error = er;
         evn.abort = ab;
         pulse();
         if (er)
            eerr = ebits | (ab ? dtf_pkg::ABORT_MASK : 8'h00);
         rd_chk(dtf_pkg::ADDR_STAT_CMD, 8'hC9, st(0, 0, er));
         rd_chk(dtf_pkg::ADDR_ERR_FEAT, 8'hFF, eerr);
         rd_chk(dtf_pkg::ADDR_COUNT, 8'hFF, cnt_v);
         rd_chk(dtf_pkg::ADDR_POSITION, 8'hFF, pos_v);
         `CHK(status_out & 8'hC9, st(0, 0, er));
      end
      host.acc(1'b1, dtf_pkg::ADDR_COUNT, 8'h99, 1'b1, q);
      rd_chk(dtf_pkg::ADDR_COUNT, 8'hFF, cnt_v);
      wr_reg(dtf_pkg::ADDR_STAT_CMD, 8'hC4);
      evn.bus_release = 1'b1;
      pulse();
      rd_chk(dtf_pkg::ADDR_STAT_CMD, 8'h88, 8'h00);
      evn.service = 1'b1;
      pulse();
      rd_chk(dtf_pkg::ADDR_STAT_CMD, 8'hD0, 8'h50);
      @(negedge clk);
      sleep = 1'b1;
      rd_chk(dtf_pkg::ADDR_ERR_FEAT, 8'hFF, dtf_pkg::SLEEP_READ);
      sleep = 1'b0;
      wr_reg(dtf_pkg::ADDR_STAT_CMD, 8'hC4);
      wr_reg(dtf_pkg::ADDR_STAT_CMD, RST_CODE);
      `CHK(cmd_code, RST_CODE);
      diag = 8'($random(seed));
      evn.diag_done = 1'b1;
      evn.complete = 1'b1;
      pulse();
      rd_chk(dtf_pkg::ADDR_ERR_FEAT, 8'hFF, diag);
      wr_reg(dtf_pkg::ADDR_STAT_CMD, 8'hC4);
      ebits = 8'h00;
      evn.complete = 1'b1;
      evn.error = 1'b1;
      pulse();
      rd_chk(dtf_pkg::ADDR_STAT_CMD, 8'h89, 8'h01);
      soft_rst = 1'b1;
      rd_chk(dtf_pkg::ADDR_STAT_CMD, 8'h80, 8'h80);
      evn.reset_ready = 1'b1;
      pulse();
      rd_chk(dtf_pkg::ADDR_STAT_CMD, 8'h89, 8'h00);
      rd_chk(dtf_pkg::ADDR_ERR_FEAT, 8'hFF, DIAG_RST);
      report_and_stop();
   end
endmodule
`default_nettype wire
